// ---- core/dram_read_interleave_sched.v ----
// How it works
// - open bank with matching row gets column reads only, no activate or precharge
// - controller compares requested row with row it recorded open per bank
// - page miss: precharge, wait, activate, wait, then first column read
// - column reads at least column cycle apart; each data packet lasts one column cycle
// - closed banks are remembered; they need an activate only, no compare
// - closing precharge waits read-to-precharge time after the bank's last column read
// - activate-to-precharge spacing is larger of minimum or activate-to-read plus read-to-precharge
// - per-request close flag is the page policy: close after reads or leave open
// - activates are spaced by the activate-to-activate time
// - a request to a bank with a pending precharge waits until it is issued
// - read streams rotate four banks; same-bank hold keeps conflicts safe
// - column rate from column cycle time, column phase from activate-to-read timer
// - a column may go one slot early with its delay bit set
// - precharges spaced by their own minimum; may go early with delay field compensating
// - one packet per request cycle on the single request bus
// - each transaction reads two packets from its bank
// - precharge bank and refresh bank fields never name the same bank
`timescale 1ns/10ps
`include "sched_map.vh"
module dram_read_interleave_sched (
    input  wire                sys_clk,
    input  wire                reset,
    input  wire                req_valid,
    output wire                req_ready,
    input  wire [2:0]          req_bank,
    input  wire [`ROW_W-1:0]   req_row,
    input  wire [`COL_W-1:0]   req_col,
    input  wire                req_close,
    input  wire [`TP_W-1:0]    t_rp,
    input  wire [`TP_W-1:0]    t_rcd,
    input  wire [`TP_W-1:0]    t_rdp,
    input  wire [`TP_W-1:0]    t_ras,
    input  wire [`TP_W-1:0]    t_rr,
    input  wire [`TP_W-1:0]    t_cc,
    input  wire [`TP_W-1:0]    t_pp,
    output wire                rq_clk,
    output wire [11:0]         request_bus,
    input  wire [`DQ_W-1:0]    dq_in,
    input  wire                dq_valid,
    output wire [`DQ_W-1:0]    rdata,
    output wire                rdata_valid,
    input  wire                rdata_ready,
    output wire                busy
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam S_IDLE  = 3'h0;
    localparam S_CLASS = 3'h1;
    localparam S_ACT   = 3'h2;
    localparam S_COL1  = 3'h3;
    localparam S_COL2  = 3'h4;

    reg  [2:0]            div_q;
    reg                   rq_clk_q;
    reg  [11:0]           bus_q;
    reg  [2:0]            st_q;
    reg                   ready_q;
    reg  [2:0]            cur_bank_q;
    reg  [`ROW_W-1:0]     cur_row_q;
    reg  [`COL_W-1:0]     cur_col_q;
    reg                   cur_close_q;
    reg  [7:0]            open_q;
    reg  [7:0]            pc_q;
    reg  [`ROW_W-1:0]     row_q [0:`NUM_BANKS-1];
    reg  [`TMR_W-1:0]     rr_q;
    reg  [`TMR_W-1:0]     cc_q;
    reg  [`TMR_W-1:0]     pp_q;
    reg  [`DQ_W-1:0]      dq_s1_q;
    reg  [`DQ_W-1:0]      dq_s2_q;
    reg                   dv_s1_q;
    reg                   dv_s2_q;
    reg  [`TP_W-1:0]      ph_q;
    reg                   push_q;
    reg  [`DQ_W-1:0]      push_data_q;
    reg  [2:0]            out_q;
    reg                   busy_q;
    wire                  tick;
    wire [8*`TMR_W-1:0]   ap_flat;
    wire [8*`TMR_W-1:0]   ar_flat;
    wire [8*`TMR_W-1:0]   rp_flat;
    wire [8*`TMR_W-1:0]   rdp_flat;
    wire [`TMR_W-1:0]     ar_b;
    wire [`TMR_W-1:0]     rp_b;
    wire [1:0]            buf_cnt;
    wire                  buf_in_ready;
    wire                  credit_ok;
    wire                  act_go;
    wire                  col_want;
    wire                  col_now;
    wire                  col_early;
    wire                  col_go;
    wire                  cdel;
    wire                  pre_go;
    wire [`TMR_W-1:0]     ras_sum;
    wire [`TMR_W-1:0]     ap_load;
    wire [`COL_W-1:0]     col_addr;
    reg                   pfound;
    reg  [2:0]            psel;
    reg  [1:0]            pwait;
    reg  [`TMR_W-1:0]     wk;
    integer               k;

    function [`TMR_W-1:0] max2;
        input [`TMR_W-1:0] a;
        input [`TMR_W-1:0] b;
        begin
            max2 = (a > b) ? a : b;
        end
    endfunction

    // ----------------------------------------
    // request clock: driven out, one tick per request cycle
    // ----------------------------------------
    assign tick   = (div_q == `RQ_DIV_LAST);
    assign rq_clk = rq_clk_q;

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            div_q    <= 3'h0;
            rq_clk_q <= 1'b0;
        end else begin
            div_q <= div_q + 3'h1;
            if (div_q == `RQ_RISE_AT)
                rq_clk_q <= 1'b1;
            else if (tick)
                rq_clk_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // per-bank countdown timers
    // ----------------------------------------
    assign ras_sum = {2'h0, t_rcd} + {2'h0, t_rdp};
    assign ap_load = max2({2'h0, t_ras}, ras_sum);
    assign cdel    = col_early;

    genvar i;
    generate
        for (i = 0; i < `NUM_BANKS; i = i + 1) begin : g_bank
            reg [`TMR_W-1:0] ap_q;
            reg [`TMR_W-1:0] ar_q;
            reg [`TMR_W-1:0] rp_q;
            reg [`TMR_W-1:0] rdp_q;
            wire             hit;
            wire             phit;
            assign hit  = (cur_bank_q == i);
            assign phit = (psel == i);
            assign ap_flat[i*`TMR_W +: `TMR_W]  = ap_q;
            assign ar_flat[i*`TMR_W +: `TMR_W]  = ar_q;
            assign rp_flat[i*`TMR_W +: `TMR_W]  = rp_q;
            assign rdp_flat[i*`TMR_W +: `TMR_W] = rdp_q;
            always @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    ap_q  <= {`TMR_W{1'b0}};
                    ar_q  <= {`TMR_W{1'b0}};
                    rp_q  <= {`TMR_W{1'b0}};
                    rdp_q <= {`TMR_W{1'b0}};
                end else if (tick) begin
                    if (act_go && hit) begin
                        ap_q <= ap_load;
                        ar_q <= {2'h0, t_rcd};
                    end else begin
                        ap_q <= (ap_q != 0) ? ap_q - 1'b1 : ap_q;
                        ar_q <= (ar_q != 0) ? ar_q - 1'b1 : ar_q;
                    end
                    if (pre_go && phit)
                        rp_q <= {2'h0, t_rp} + {6'h00, pwait};
                    else if (rp_q != 0)
                        rp_q <= rp_q - 1'b1;
                    if (col_go && hit)
                        rdp_q <= {2'h0, t_rdp} + {7'h00, cdel};
                    else if (rdp_q != 0)
                        rdp_q <= rdp_q - 1'b1;
                end
            end
        end
    endgenerate

    assign ar_b = ar_flat[{cur_bank_q, 3'h0} +: `TMR_W];
    assign rp_b = rp_flat[{cur_bank_q, 3'h0} +: `TMR_W];

    // ----------------------------------------
    // slot allocation
    // ----------------------------------------
    // the two-entry buffer bounds reads in flight; long read delays therefore leave gaps
    assign credit_ok = ({1'b0, out_q} + {2'h0, buf_cnt}) < {1'b0, `READ_CREDITS};
    assign act_go    = tick && (st_q == S_ACT) && !pc_q[cur_bank_q]
                       && (rp_b == 0) && (rr_q == 0);
    assign col_want  = ((st_q == S_COL1) || (st_q == S_COL2)) && credit_ok;
    assign col_now   = col_want && (cc_q == 0) && (ar_b == 0);
    assign col_early = col_want && !col_now && (cc_q <= `COL_DELAY_MAX)
                       && (ar_b <= `COL_DELAY_MAX);
    assign col_go    = tick && (col_now || col_early);
    assign col_addr  = (st_q == S_COL2) ? cur_col_q + 1'b1 : cur_col_q;
    assign pre_go    = tick && pfound && !act_go && !col_go;

    // lowest closable bank; a wait up to the delay field's reach is absorbed by it
    always @* begin
        pfound = 1'b0;
        psel   = 3'h0;
        pwait  = 2'h0;
        wk     = {`TMR_W{1'b0}};
        for (k = `NUM_BANKS - 1; k >= 0; k = k - 1) begin
            wk = max2(max2(ap_flat[k*`TMR_W +: `TMR_W], rdp_flat[k*`TMR_W +: `TMR_W]), pp_q);
            if (pc_q[k] && (wk <= `PRE_DELAY_MAX)) begin
                pfound = 1'b1;
                psel   = k[2:0];
                pwait  = wk[1:0];
            end
        end
    end

    // ----------------------------------------
    // global spacing timers
    // ----------------------------------------
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rr_q <= {`TMR_W{1'b0}};
            cc_q <= {`TMR_W{1'b0}};
            pp_q <= {`TMR_W{1'b0}};
        end else if (tick) begin
            if (act_go)
                rr_q <= {2'h0, t_rr};
            else if (rr_q != 0)
                rr_q <= rr_q - 1'b1;
            if (col_go)
                cc_q <= {2'h0, t_cc} + {7'h00, cdel};
            else if (cc_q != 0)
                cc_q <= cc_q - 1'b1;
            if (pre_go)
                pp_q <= {2'h0, t_pp} + {6'h00, pwait};
            else if (pp_q != 0)
                pp_q <= pp_q - 1'b1;
        end
    end

    // ----------------------------------------
    // request bus, one packet per request cycle
    // ----------------------------------------
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            bus_q <= 12'h000;
        end else if (tick) begin
            if (act_go)
                bus_q <= {`OP_ACT, cur_bank_q, cur_row_q};
            else if (col_go)
                bus_q <= {`OP_COL, cur_bank_q, cdel, col_addr};
            else if (pre_go)
                bus_q <= {`OP_PRE, psel, pwait, psel ^ 3'h1, 1'b0, 1'b0};
            else
                bus_q <= 12'h000;
        end
    end
    assign request_bus = bus_q;

    // ----------------------------------------
    // transaction sequencer and bank state
    // ----------------------------------------
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_q        <= S_IDLE;
            ready_q     <= 1'b0;
            cur_bank_q  <= 3'h0;
            cur_row_q   <= {`ROW_W{1'b0}};
            cur_col_q   <= {`COL_W{1'b0}};
            cur_close_q <= 1'b0;
            open_q      <= 8'h00;
            pc_q        <= 8'h00;
        end else begin
            if (pre_go) begin
                open_q[psel] <= 1'b0;
                pc_q[psel]   <= 1'b0;
            end
            case (st_q)
                S_IDLE: begin
                    ready_q <= 1'b1;
                    if (req_valid && ready_q) begin
                        ready_q     <= 1'b0;
                        cur_bank_q  <= req_bank;
                        cur_row_q   <= req_row;
                        cur_col_q   <= req_col;
                        cur_close_q <= req_close;
                        st_q        <= S_CLASS;
                    end
                end
                S_CLASS: begin
                    // requester rotates banks; a repeated bank waits here only while its precharge is pending
                    if (!pc_q[cur_bank_q]) begin
                        if (open_q[cur_bank_q] && (row_q[cur_bank_q] == cur_row_q)) begin
                            st_q <= S_COL1;
                        end else if (open_q[cur_bank_q]) begin
                            pc_q[cur_bank_q] <= 1'b1;
                            st_q             <= S_ACT;
                        end else begin
                            st_q <= S_ACT;
                        end
                    end
                end
                S_ACT: begin
                    if (act_go) begin
                        open_q[cur_bank_q] <= 1'b1;
                        st_q               <= S_COL1;
                    end
                end
                S_COL1: begin
                    if (col_go)
                        st_q <= S_COL2;
                end
                S_COL2: begin
                    if (col_go) begin
                        if (cur_close_q)
                            pc_q[cur_bank_q] <= 1'b1;
                        st_q    <= S_IDLE;
                        ready_q <= 1'b1;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (act_go)
            row_q[cur_bank_q] <= cur_row_q;
    end
    assign req_ready = ready_q;

    // ----------------------------------------
    // read data capture
    // ----------------------------------------
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dq_s1_q     <= {`DQ_W{1'b0}};
            dq_s2_q     <= {`DQ_W{1'b0}};
            dv_s1_q     <= 1'b0;
            dv_s2_q     <= 1'b0;
            ph_q        <= {`TP_W{1'b0}};
            push_q      <= 1'b0;
            push_data_q <= {`DQ_W{1'b0}};
            out_q       <= 3'h0;
            busy_q      <= 1'b0;
        end else begin
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
            dv_s1_q <= dq_valid;
            dv_s2_q <= dv_s1_q;
            push_q  <= 1'b0;
            if (tick) begin
                if (ph_q != 0) begin
                    ph_q <= ph_q - 1'b1;
                end else if (dv_s2_q) begin
                    push_q      <= 1'b1;
                    push_data_q <= dq_s2_q;
                    ph_q        <= t_cc - 1'b1;
                end
            end
            case ({col_go, push_q})
                2'b10:   out_q <= out_q + 3'h1;
                2'b01:   out_q <= (out_q != 0) ? out_q - 3'h1 : out_q;
                default: out_q <= out_q;
            endcase
            busy_q <= (st_q != S_IDLE) || (pc_q != 8'h00) || (out_q != 3'h0);
        end
    end
    assign busy = busy_q;

    two_entry_buffer u_rbuf (
        .clk       (sys_clk),
        .reset     (reset),
        .in_valid  (push_q),
        .in_ready  (buf_in_ready),
        .in_data   (push_data_q),
        .out_valid (rdata_valid),
        .out_ready (rdata_ready),
        .out_data  (rdata),
        .count     (buf_cnt)
    );
endmodule

// ---- core/sched_map.vh ----
`ifndef SCHED_MAP_VH
`define SCHED_MAP_VH
// ----------------------------------------
// request clock divider
// ----------------------------------------
`define RQ_DIV_LAST    3'h7
`define RQ_RISE_AT     3'h3
// ----------------------------------------
// request packet layout on request_bus
// ----------------------------------------
`define OP_MSB         11
`define OP_LSB         10
`define OP_NOP         2'h0
`define OP_ACT         2'h1
`define OP_COL         2'h2
`define OP_PRE         2'h3
`define BANK_MSB       9
`define BANK_LSB       7
`define ROW_W          7
`define COL_W          6
`define COL_DELAY_BIT  6
`define PRE_DELAY_MSB  6
`define PRE_DELAY_LSB  5
`define REF_BANK_MSB   4
`define REF_BANK_LSB   2
`define REF_EN_BIT     1
// ----------------------------------------
// scheduler limits
// ----------------------------------------
`define TP_W           6
`define TMR_W          8
`define PRE_DELAY_MAX  8'h03
`define COL_DELAY_MAX  8'h01
`define READ_CREDITS   3'h2
`define DQ_W           16
`define NUM_BANKS      8
`endif

// ---- core/two_entry_buffer.v ----
`timescale 1ns/10ps
`include "sched_map.vh"
module two_entry_buffer (
    input  wire             clk,
    input  wire             reset,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [`DQ_W-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [`DQ_W-1:0] out_data,
    output wire [1:0]       count
);
    // ----------------------------------------
    // shift-style storage, head always entry 0
    // ----------------------------------------
    reg [`DQ_W-1:0] e0_q;
    reg [`DQ_W-1:0] e1_q;
    reg             v0_q;
    reg             v1_q;
    wire            pop;
    wire            push;

    assign pop       = v0_q & out_ready;
    assign in_ready  = ~v1_q;
    assign push      = in_valid & ~v1_q;
    assign out_valid = v0_q;
    assign out_data  = e0_q;
    assign count     = {1'b0, v0_q} + {1'b0, v1_q};

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            e0_q <= {`DQ_W{1'b0}};
            e1_q <= {`DQ_W{1'b0}};
            v0_q <= 1'b0;
            v1_q <= 1'b0;
        end else begin
            if (pop) begin
                if (v1_q) begin
                    e0_q <= e1_q;
                    v0_q <= 1'b1;
                    v1_q <= push;
                    e1_q <= in_data;
                end else begin
                    v0_q <= push;
                    e0_q <= in_data;
                end
            end else if (push) begin
                if (v0_q) begin
                    e1_q <= in_data;
                    v1_q <= 1'b1;
                end else begin
                    e0_q <= in_data;
                    v0_q <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- sim/dram_device_model.sv ----
`timescale 1ns/10ps
module dram_device_model #(parameter int READ_DATA_DELAY = 3) (
    input  wire logic        rq_clk,
    input  wire logic [11:0] request_bus,
    input  var  logic [5:0]  tp [7],
    output logic      [15:0] dq_in,
    output logic             dq_valid,
    output int               cnt [4]
);
    // ------
    // bank state; cnt holds activates, columns, precharges, timing faults
    // ------
    int          cyc = 0;
    int          left = 0;
    int          e;
    int          tr [7];
    int          act_t [8];
    int          pre_t [8];
    int          col_t [8];
    int          last_act = -99;
    int          last_col = -99;
    int          last_pre = -99;
    logic        open_b [8];
    logic [6:0]  row_b [8];
    int          st_q [$];
    logic [15:0] dt_q [$];
    wire  [2:0]  b_w = request_bus[9:7];

    initial begin
        dq_in = 16'h0000;
        dq_valid = 1'b0;
        cnt = '{0, 0, 0, 0};
        foreach (open_b[i]) begin
            open_b[i] = 1'b0;
            act_t[i] = -99;
            pre_t[i] = -99;
            col_t[i] = -99;
        end
    end

    always @(posedge rq_clk) begin
        foreach (tp[k]) tr[k] = tp[k];
        cyc = cyc + 1;
        case (request_bus[11:10])
            2'h1: begin
                cnt[0]++;
                if (open_b[b_w] || cyc - pre_t[b_w] < tr[0] || cyc - last_act < tr[4]) cnt[3]++;
                open_b[b_w] = 1'b1;
                row_b[b_w] = request_bus[6:0];
                act_t[b_w] = cyc;
                last_act = cyc;
            end
            2'h2: begin
                e = cyc + request_bus[6];
                cnt[1]++;
                if (!open_b[b_w] || e - act_t[b_w] < tr[1] || e - last_col < tr[5]) cnt[3]++;
                col_t[b_w] = e;
                last_col = e;
                st_q.push_back(e + READ_DATA_DELAY);
                dt_q.push_back({b_w, row_b[b_w], request_bus[5:0]});
            end
            2'h3: begin
                e = cyc + request_bus[6:5];
                cnt[2]++;
                if (!open_b[b_w] || e - act_t[b_w] < tr[3] || e - act_t[b_w] < tr[1] + tr[2]) cnt[3]++;
                if (e - col_t[b_w] < tr[2] || e - last_pre < tr[6] || request_bus[4:2] == b_w) cnt[3]++;
                open_b[b_w] = 1'b0;
                pre_t[b_w] = e;
                last_pre = e;
            end
            default: ;
        endcase
        if (left > 0) left = left - 1;
        // a released data line shows the inverse so a late capture cannot match
        if (left == 0 && dq_valid) begin
            dq_valid <= 1'b0;
            dq_in <= ~dq_in;
        end
        if (st_q.size() > 0 && st_q[0] == cyc) begin
            dq_in <= dt_q.pop_front();
            dq_valid <= 1'b1;
            left = tr[5];
            void'(st_q.pop_front());
        end
    end
endmodule

// ---- sim/dram_read_interleave_sched_checker.sv ----
`timescale 1ns/10ps
`include "sched_map.vh"
module dram_read_interleave_sched_checker (
    input wire logic             sys_clk,
    input wire logic             reset,
    input wire logic             req_valid,
    input wire logic             req_ready,
    input wire logic [`TP_W-1:0] t_rr,
    input wire logic [`TP_W-1:0] t_cc,
    input wire logic [`TP_W-1:0] t_pp,
    input wire logic             rq_clk,
    input wire logic [11:0]      request_bus,
    input wire logic [`DQ_W-1:0] rdata,
    input wire logic             rdata_valid,
    input wire logic             rdata_ready,
    input wire logic             busy
);
    // ------
    // request cycles since last packet of each kind
    // ------
    logic       rq_q;
    logic [7:0] act_gap_q;
    logic [7:0] col_gap_q;
    logic [7:0] pre_gap_q;
    logic       col_del_q;
    logic [1:0] pre_del_q;
    wire        fall_w = rq_q & ~rq_clk;
    wire  [1:0] op_w   = request_bus[11:10];

    // saturate low so sums with delay fields never wrap
    function automatic logic [7:0] step(input logic [7:0] v);
        return (v == 8'h7f) ? v : v + 8'h01;
    endfunction

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rq_q      <= 1'b0;
            act_gap_q <= 8'h7f;
            col_gap_q <= 8'h7f;
            pre_gap_q <= 8'h7f;
            col_del_q <= 1'b0;
            pre_del_q <= 2'h0;
        end else begin
            rq_q <= rq_clk;
            if (fall_w) begin
                act_gap_q <= (op_w == 2'h1) ? 8'h01 : step(act_gap_q);
                col_gap_q <= (op_w == 2'h2) ? 8'h01 : step(col_gap_q);
                pre_gap_q <= (op_w == 2'h3) ? 8'h01 : step(pre_gap_q);
                if (op_w == 2'h2) col_del_q <= request_bus[6];
                if (op_w == 2'h3) pre_del_q <= request_bus[6:5];
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    clk_shape_a: assert property ($rose(rq_clk) |=> rq_clk [*3] ##1 !rq_clk [*4] ##1 rq_clk)
        else $error("request clock shape wrong");
    word_hold_a: assert property (fall_w |=> $stable(request_bus) [*7])
        else $error("request word not held a full request cycle");
    word_edge_a: assert property ($changed(request_bus) |-> fall_w)
        else $error("request word changed off the falling request clock");
    bank_pair_a: assert property (op_w == 2'h3 |-> request_bus[4:2] != request_bus[9:7] && !request_bus[1])
        else $error("precharge and refresh bank fields clash");
    act_gap_a: assert property (fall_w && op_w == 2'h1 |-> act_gap_q >= t_rr)
        else $error("activates too close");
    col_gap_a: assert property (fall_w && op_w == 2'h2 |-> col_gap_q + request_bus[6] >= t_cc + col_del_q)
        else $error("column reads too close");
    pre_gap_a: assert property (fall_w && op_w == 2'h3 |-> pre_gap_q + request_bus[6:5] >= t_pp + pre_del_q)
        else $error("precharges too close");
    ready_drop_a: assert property (req_valid && req_ready |=> !req_ready)
        else $error("second request taken before first finished");
    out_hold_a: assert property (rdata_valid && !rdata_ready |=> rdata_valid && $stable(rdata))
        else $error("stalled read word lost or changed");
endmodule

bind dram_read_interleave_sched dram_read_interleave_sched_checker chk_u (
    .sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready), .t_rr(t_rr),
    .t_cc(t_cc), .t_pp(t_pp), .rq_clk(rq_clk), .request_bus(request_bus), .rdata(rdata),
    .rdata_valid(rdata_valid), .rdata_ready(rdata_ready), .busy(busy)
);

// ---- sim/dram_read_interleave_sched_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module dram_read_interleave_sched_tb_top;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic        req_valid = 1'b0;
    logic        req_close = 1'b0;
    logic        rdata_ready = 1'b1;
    logic [2:0]  req_bank = 3'h0;
    logic [6:0]  req_row = 7'h00;
    logic [5:0]  req_col = 6'h00;
    logic [5:0]  tp [7] = '{6'h03, 6'h03, 6'h03, 6'h0a, 6'h04, 6'h02, 6'h04};
    wire         req_ready;
    wire         rq_clk;
    wire         dq_valid;
    wire         rdata_valid;
    wire         busy;
    wire  [11:0] request_bus;
    wire  [15:0] dq_in;
    wire  [15:0] rdata;
    int          cnt [4];
    int          base [4] = '{0, 0, 0, 0};
    int          errors = 0;
    int          checked = 0;
    int          cycles = 0;
    logic [15:0] exp_q [$];
    logic [15:0] got_q [$];

    always #10 sys_clk = ~sys_clk;

    dram_read_interleave_sched dut_u (
        .sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
        .req_bank(req_bank), .req_row(req_row), .req_col(req_col), .req_close(req_close),
        .t_rp(tp[0]), .t_rcd(tp[1]), .t_rdp(tp[2]), .t_ras(tp[3]), .t_rr(tp[4]), .t_cc(tp[5]),
        .t_pp(tp[6]), .rq_clk(rq_clk), .request_bus(request_bus), .dq_in(dq_in), .dq_valid(dq_valid),
        .rdata(rdata), .rdata_valid(rdata_valid), .rdata_ready(rdata_ready), .busy(busy)
    );

    // slow answer: read delay longer than the column spacing
    dram_device_model #(.READ_DATA_DELAY(5)) mdl_u (
        .rq_clk(rq_clk), .request_bus(request_bus), .tp(tp), .dq_in(dq_in), .dq_valid(dq_valid), .cnt(cnt)
    );

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (rdata_valid === 1'b1 && rdata_ready) got_q.push_back(rdata);
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("counts: checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // request is held until taken; two column words are expected back
    task automatic send(input logic [2:0] b, input logic [6:0] r, input logic [5:0] c, input logic cl);
        int n;
        n = 0;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_bank <= b;
        req_row <= r;
        req_col <= c;
        req_close <= cl;
        exp_q.push_back({b, r, c});
        exp_q.push_back({b, r, c + 6'h01});
        @(posedge sys_clk);
        while (req_ready !== 1'b1 && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        req_valid <= 1'b0;
    endtask

    task automatic finish_test(input string nm, input int a, input int c, input int p);
        int n;
        n = 0;
        while ((got_q.size() < exp_q.size() || busy !== 1'b0 || cnt[2] - base[2] < p) && n < 4000) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK("activates", a, cnt[0] - base[0]);
        `CHK("column reads", c, cnt[1] - base[1]);
        `CHK("precharges", p, cnt[2] - base[2]);
        `CHK("timing faults", 0, cnt[3] - base[3]);
        `CHK("word count", exp_q.size(), got_q.size());
        foreach (exp_q[i]) `CHK("rdata", exp_q[i], got_q[i]);
        base = cnt;
        exp_q.delete();
        got_q.delete();
        $display("test %s done", nm);
    endtask

    // column wraps from the last column to zero
    task automatic t_empty();
        send(3'h0, 7'h05, 6'h3f, 1'b0);
        finish_test("page empty", 1, 2, 0);
    endtask

    task automatic t_hit();
        send(3'h0, 7'h05, 6'h10, 1'b1);
        finish_test("page hit", 0, 2, 1);
    endtask

    task automatic t_miss();
        send(3'h1, 7'h03, 6'h00, 1'b0);
        send(3'h1, 7'h04, 6'h01, 1'b0);
        finish_test("page miss", 2, 4, 1);
    endtask

    // four banks in rotation, then a repeat of the first; reader stalls meanwhile
    task automatic t_inter();
        logic [2:0] bk [5];
        bk = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h2};
        @(posedge sys_clk);
        rdata_ready <= 1'b0;
        fork
            begin
                repeat (400) @(posedge sys_clk);
                rdata_ready <= 1'b1;
            end
        join_none
        for (int i = 0; i < 5; i++) send(bk[i], 7'h10 + 7'(i), 6'(8 * i), 1'b1);
        finish_test("interleave", 5, 10, 5);
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        t_empty();
        t_hit();
        t_miss();
        t_inter();
        give_verdict();
    end
endmodule
